// [rtl/sprs_pkg.sv]
package sprs_pkg;

  // ----------------------------------------------------------------------
  // Timing constants
  // ----------------------------------------------------------------------
  localparam int unsigned OSC_HZ           = 32768;   // Internal oscillator rate
  localparam int unsigned SYS_CLK_HZ       = 40000000;
  localparam int unsigned DEBOUNCE_MS      = 250;     // Pushbutton debounce time
  localparam int unsigned RST_HOLD_MS      = 250;     // Reset hold time
  localparam int unsigned REC_HOLD_MS      = 250;     // Recovery hold time
  localparam int unsigned CONV_PERIOD_S    = 64;      // Default conversion period
  localparam int unsigned DEBOUNCE_TICKS   = (OSC_HZ * DEBOUNCE_MS) / 1000;
  localparam int unsigned RST_HOLD_TICKS   = (OSC_HZ * RST_HOLD_MS) / 1000;
  localparam int unsigned REC_HOLD_TICKS   = (OSC_HZ * REC_HOLD_MS) / 1000;
  localparam int unsigned CONV_PERIOD_SECS = CONV_PERIOD_S;

  // ----------------------------------------------------------------------
  // Conversion-rate field encoding (hi, lo)
  // ----------------------------------------------------------------------
  localparam logic [1:0] CRATE_64S  = 2'h0;
  localparam logic [1:0] CRATE_128S = 2'h1;
  localparam logic [1:0] CRATE_256S = 2'h2;
  localparam logic [1:0] CRATE_512S = 2'h3;

  // ----------------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned TEMP_W   = 10;
  localparam int unsigned CAP_W    = 8;
  localparam logic [7:0]  CAP_RST  = 8'h80;

endpackage : sprs_pkg

// [rtl/sprs_comp_if.sv]
`timescale 1ns/10ps
// Path between supervisor and compensation controller
interface sprs_comp_if;
  logic                            conv_req;   // Start a conversion
  logic                            temp_vld;   // Temperature result valid
  logic [sprs_pkg::TEMP_W-1:0]     temp;       // Measured temperature
  logic [7:0]                      aging;      // Signed aging offset
  logic [sprs_pkg::CAP_W-1:0]      cap;        // Capacitance selection
  logic                            cap_upd;    // Capacitance written

  modport sup (output conv_req, output aging, input temp_vld, input temp,
               input cap, input cap_upd);
  modport cmp (input conv_req, input aging, input temp_vld, input temp,
               output cap, output cap_upd);
endinterface : sprs_comp_if

// [rtl/sprs_comp.sv]
`timescale 1ns/10ps
// Temperature to capacitance compensation controller
module sprs_comp (
  input  wire logic   sys_clk_i,
  input  wire logic   rst_i,
  input  wire logic   ce_i,
  sprs_comp_if.cmp    cif
);

  // ----------------------------------------------------------------------
  // Lookup table and state
  // ----------------------------------------------------------------------
  logic [sprs_pkg::CAP_W-1:0]  lut [0:63];
  logic [sprs_pkg::TEMP_W-1:0] last_temp;
  logic                        have_temp;
  logic [sprs_pkg::CAP_W-1:0]  cap;
  logic                        cap_upd;
  logic [sprs_pkg::CAP_W-1:0]  next_cap;

  // Table falls with temperature, constant contents
  genvar g;
  generate
    for (g = 0; g < 64; g++) begin : g_lut
      assign lut[g] = 8'(8'hC0 - (g * 2));
    end
  endgenerate

  // Table lookup plus signed aging offset
  always_comb begin
    next_cap = 8'(lut[cif.temp[sprs_pkg::TEMP_W-1 -: 6]] + cif.aging);   // R10
  end

  // Load only on a changed temperature
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cap       <= sprs_pkg::CAP_RST;
      last_temp <= '0;
      have_temp <= 1'b0;
      cap_upd   <= 1'b0;
    end else if (ce_i) begin
      cap_upd <= 1'b0;
      if (cif.temp_vld && (!have_temp || cif.temp != last_temp)) begin   // R11
        cap       <= next_cap;                                          // R10
        last_temp <= cif.temp;
        have_temp <= 1'b1;
        cap_upd   <= 1'b1;
      end
    end
  end

  assign cif.cap     = cap;
  assign cif.cap_upd = cap_upd;

  AST_CAP_ON_CHANGE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ce_i && cif.temp_vld && have_temp && cif.temp == last_temp |=> !cap_upd) // R11
    else $error("capacitance reloaded on unchanged temperature");
  AST_CAP_VALUE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    cap_upd |-> cap == 8'(lut[last_temp[sprs_pkg::TEMP_W-1 -: 6]]
                          + $past(cif.aging)))                         // R10
    else $error("capacitance does not match table plus aging");

endmodule : sprs_comp

// [rtl/sprs_top.sv]
`timescale 1ns/10ps
// Behaviour
// R1 - Reset line is pulled low whenever main supply is below the power-fail threshold.
// R2 - After supply recovers, reset stays low for the hold time, then is released.
// R3 - If the oscillator is stopped or not running at recovery, reset releases at once.
// R4 - Outside a reset cycle, the reset line is watched for a pushbutton falling edge.
// R5 - On that edge the device drives reset low for the debounce interval.
// R6 - After debounce, a still-low line is watched for the rising edge of release.
// R7 - After release, reset is driven low for the reset hold time, then released.
// R8 - Reset assertion never disturbs timekeeping or other internal operation.
// R9 - A conversion runs at first supply, then every 64 s or the rate field's period.
// R10 - Capacitance is table(temperature) plus signed aging offset.
// R11 - Capacitance reloads only when temperature differs from the previous one.
// R12 - Battery powers the device only when supply is below threshold and battery.
// R13 - On first battery attach, oscillator and conversions wait for supply or bus address.
// R14 - After first supply ramp the oscillator runs, also on battery later.
// R15 - On battery, the stop bit halts the oscillator into data retention.
// R16 - Debounce and hold times are parameterised counts of 32 kHz ticks.
module sprs_top #(
  parameter int unsigned DEBOUNCE_TICKS = sprs_pkg::DEBOUNCE_TICKS,
  parameter int unsigned RST_TICKS      = sprs_pkg::RST_HOLD_TICKS,
  parameter int unsigned REC_TICKS      = sprs_pkg::REC_HOLD_TICKS,
  parameter int unsigned TICKS_PER_SEC  = sprs_pkg::OSC_HZ
) (
  input  wire logic                         sys_clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         ce_i,
  input  wire logic                         osc_tick_i,      // 32 kHz tick, same domain
  input  wire logic                         vcc_above_pf_i,  // Comparator, async
  input  wire logic                         vcc_above_bat_i, // Comparator, async
  input  wire logic                         rst_pin_i,       // Reset line level
  input  wire logic                         addr_match_i,    // Valid bus address seen
  input  wire logic                         oscillator_stop_bit_i,
  input  wire logic                         conversion_rate_hi_i,
  input  wire logic                         conversion_rate_lo_i,
  input  wire logic [7:0]                   aging_offset_i,
  input  wire logic [sprs_pkg::TEMP_W-1:0]  temp_i,
  input  wire logic                         temp_vld_i,
  output logic                              rst_pin_o,       // Always 0 when driven
  output logic                              rst_pin_oe_n_o,  // Low while driving
  output logic                              on_battery_o,
  output logic                              osc_run_o,
  output logic                              conv_req_o,
  output logic [sprs_pkg::CAP_W-1:0]        cap_o,
  output logic                              cap_upd_o
);

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  logic [2:0] pf_s, bat_s, pin_s;
  logic       pf_ok, bat_lo, pin_hi;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pf_s  <= 3'h0;
      bat_s <= 3'h7;
      pin_s <= 3'h7;
    end else if (ce_i) begin
      pf_s  <= {pf_s[1:0], vcc_above_pf_i};
      bat_s <= {bat_s[1:0], vcc_above_bat_i};
      pin_s <= {pin_s[1:0], rst_pin_i};
    end
  end

  // Filtered levels change only when stages two and three agree
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pf_ok  <= 1'b0;
      bat_lo <= 1'b0;
      pin_hi <= 1'b1;
    end else if (ce_i) begin
      if (pf_s[1] == pf_s[2]) pf_ok <= pf_s[2];
      if (bat_s[1] == bat_s[2]) bat_lo <= !bat_s[2];
      if (pin_s[1] == pin_s[2]) pin_hi <= pin_s[2];
    end
  end

  // ----------------------------------------------------------------------
  // Supply selection and oscillator enable
  // ----------------------------------------------------------------------
  logic armed;     // Oscillator allowed after first supply or address
  logic osc_run;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      on_battery_o <= 1'b0;
    end else if (ce_i) begin
      on_battery_o <= !pf_ok && bat_lo;                                   // R12
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      armed <= 1'b0;
    end else if (ce_i && (pf_ok || addr_match_i)) begin
      armed <= 1'b1;                                                      // R13 R14
    end
  end

  assign osc_run = armed && !(on_battery_o && oscillator_stop_bit_i);     // R15

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      osc_run_o <= 1'b0;
    end else if (ce_i) begin
      osc_run_o <= osc_run;                                               // R14
    end
  end

  // ----------------------------------------------------------------------
  // Reset line sequencer
  // ----------------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_PFAIL = 6'b000010,
    ST_HOLD  = 6'b000100,
    ST_DEB   = 6'b001000,
    ST_WREL  = 6'b010000,
    ST_PBRST = 6'b100000
  } sprs_state_t;

  sprs_state_t state, next_state;
  logic [31:0] cnt;
  logic        pin_hi_d;
  logic        fall_edge, rise_edge, cnt_done;

  assign fall_edge = pin_hi_d && !pin_hi;
  assign rise_edge = !pin_hi_d && pin_hi;
  assign cnt_done  = (cnt == 32'h0) && osc_tick_i;                        // R16

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) pin_hi_d <= 1'b1;
    else if (ce_i) pin_hi_d <= pin_hi;
  end

  // State transitions; power fail overrides any pushbutton cycle
  always_comb begin
    next_state = state;
    unique case (state)
      ST_PFAIL: begin
        if (pf_ok) next_state = osc_run_o ? ST_HOLD : ST_IDLE;           // R2 R3
      end
      ST_IDLE: begin
        if (fall_edge) next_state = ST_DEB;                               // R4
      end
      ST_DEB: begin
        if (cnt_done) next_state = pin_hi ? ST_IDLE : ST_WREL;            // R6
      end
      ST_WREL: begin
        if (rise_edge) next_state = ST_PBRST;                             // R7
      end
      ST_HOLD, ST_PBRST: begin
        if (cnt_done) next_state = ST_IDLE;
      end
    endcase
    if (!pf_ok) next_state = ST_PFAIL;                                    // R1
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) state <= ST_PFAIL;
    else if (ce_i) state <= next_state;
  end

  // Interval counter in oscillator ticks, loaded on entry
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 32'h0;
    end else if (ce_i) begin
      if (next_state != state) begin
        unique case (next_state)
          ST_DEB:   cnt <= DEBOUNCE_TICKS - 1;                            // R5
          ST_HOLD:  cnt <= REC_TICKS - 1;                                 // R2
          ST_PBRST: cnt <= RST_TICKS - 1;                                 // R7
          default:  cnt <= 32'h0;
        endcase
      end else if (osc_tick_i && cnt != 32'h0) begin
        cnt <= cnt - 32'h1;
      end
    end
  end

  // Open-drain drive; only the pin, nothing internal, follows reset
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rst_pin_oe_n_o <= 1'b0;
    end else if (ce_i) begin
      rst_pin_oe_n_o <= !(next_state inside {ST_PFAIL, ST_HOLD, ST_DEB, ST_PBRST}); // R8
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) rst_pin_o <= 1'b0;
    else if (ce_i) rst_pin_o <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // Conversion scheduler
  // ----------------------------------------------------------------------
  logic [15:0] sub_cnt;
  logic [9:0]  sec_cnt;
  logic        first_done;
  logic [9:0]  period;

  always_comb begin
    unique case ({conversion_rate_hi_i, conversion_rate_lo_i})
      sprs_pkg::CRATE_64S:  period = 10'(sprs_pkg::CONV_PERIOD_SECS);
      sprs_pkg::CRATE_128S: period = 10'(sprs_pkg::CONV_PERIOD_SECS * 2);
      sprs_pkg::CRATE_256S: period = 10'(sprs_pkg::CONV_PERIOD_SECS * 4);
      default:              period = 10'(sprs_pkg::CONV_PERIOD_SECS * 8);
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sub_cnt    <= 16'h0;
      sec_cnt    <= 10'h0;
      first_done <= 1'b0;
      conv_req_o <= 1'b0;
    end else if (ce_i) begin
      conv_req_o <= 1'b0;
      if (osc_run) begin                                                  // R13
        if (!first_done && pf_ok) begin
          conv_req_o <= 1'b1;                                             // R9
          first_done <= 1'b1;
        end else if (osc_tick_i) begin
          if (sub_cnt == 16'(TICKS_PER_SEC - 1)) begin
            sub_cnt <= 16'h0;
            if (sec_cnt >= period - 10'h1) begin
              sec_cnt    <= 10'h0;
              conv_req_o <= 1'b1;                                         // R9
            end else begin
              sec_cnt <= sec_cnt + 10'h1;
            end
          end else begin
            sub_cnt <= sub_cnt + 16'h1;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Compensation controller
  // ----------------------------------------------------------------------
  sprs_comp_if cif ();
  assign cif.conv_req = conv_req_o;
  assign cif.aging    = aging_offset_i;
  assign cif.temp     = temp_i;
  assign cif.temp_vld = temp_vld_i && armed;

  sprs_comp u_comp (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .cif       (cif)
  );

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cap_o     <= sprs_pkg::CAP_RST;
      cap_upd_o <= 1'b0;
    end else if (ce_i) begin
      cap_o     <= cif.cap;
      cap_upd_o <= cif.cap_upd;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_recover;
    state == ST_PFAIL ##1 state == ST_HOLD;
  endsequence

  AST_PF_DRIVES: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ce_i && !pf_ok |=> !rst_pin_oe_n_o)                                   // R1
    else $error("reset line not driven during power fail");
  AST_HOLD_LOW: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_recover |-> !rst_pin_oe_n_o)                                        // R2
    else $error("reset released at start of recovery hold");
  AST_BYPASS: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ce_i && state == ST_PFAIL && pf_ok && !osc_run_o |=> state == ST_IDLE) // R3
    else $error("hold not bypassed with oscillator stopped");
  AST_PB_EDGE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ce_i && pf_ok && state == ST_IDLE && fall_edge |=> state == ST_DEB)   // R4
    else $error("pushbutton edge missed");
  AST_DEB_DRIVE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    state == ST_DEB |-> !rst_pin_oe_n_o)                                  // R5
    else $error("reset not driven during debounce");
  AST_WREL: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ce_i && pf_ok && state == ST_DEB && cnt_done && !pin_hi |=> state == ST_WREL) // R6
    else $error("still-low line not followed to release wait");
  AST_PB_RST: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ce_i && pf_ok && state == ST_WREL && rise_edge |=> state == ST_PBRST ##1 !rst_pin_oe_n_o) // R7
    else $error("release not followed by reset pulse");
  AST_BATTERY: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ce_i |=> on_battery_o == $past(!pf_ok && bat_lo))                     // R12
    else $error("wrong supply selected");
  AST_NO_EARLY_CONV: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !armed |=> !conv_req_o)                                               // R13
    else $error("conversion before first arm");
  AST_STOP: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ce_i && on_battery_o && oscillator_stop_bit_i |=> !osc_run_o)         // R15
    else $error("oscillator not halted by stop bit");

endmodule : sprs_top

// [tb/sprs_button_model.sv]
`timescale 1ns/10ps
// Pushbutton switch and host reset input on the open-drain reset line
module sprs_button_model (
  input  wire logic press_i,
  input  wire logic drv_i,
  input  wire logic oe_n_i,
  output logic      line_o,
  output logic      host_rst_n_o
);
  // --------------------------------------------------------------------
  // Wired-AND reset line with internal pull-up
  // --------------------------------------------------------------------
  // Device or closed switch pulls low, otherwise the pull-up wins
  assign line_o       = ((!oe_n_i && !drv_i) || press_i) ? 1'b0 : 1'b1;
  // Host reset input follows the resolved line
  assign host_rst_n_o = line_o;
endmodule : sprs_button_model

// [tb/tb_sprs_top.sv]
`timescale 1ns/10ps
module tb_sprs_top;
  // --------------------------------------------------------------------
  // Shortened counts and tick divider
  // --------------------------------------------------------------------
  localparam int TDIV = 4;
  localparam int DB   = 4;
  localparam int RSTT = 6;
  localparam int REC  = 5;
  localparam int TPS  = 8;

  logic       sys_clk = 1'b0;
  logic       rst, tick, pf, bat, addr, stop, rate_hi, rate_lo, temp_vld, press, ce;
  logic [7:0] aging, cap;
  logic [9:0] temp;
  logic       line, host_rst_n, drv, oe_n, on_bat, osc_run, conv_req, cap_upd;
  int         error_cnt, comparisons, tick_cnt;

  // Clock and oscillator tick, one pulse every TDIV cycles
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    #2;
    tick_cnt = (tick_cnt + 1) % TDIV;
    tick     = (tick_cnt == 0);
  end

  sprs_top #(.DEBOUNCE_TICKS(DB), .RST_TICKS(RSTT), .REC_TICKS(REC), .TICKS_PER_SEC(TPS)) dut (
    .sys_clk_i(sys_clk), .rst_i(rst), .ce_i(ce), .osc_tick_i(tick),
    .vcc_above_pf_i(pf), .vcc_above_bat_i(bat), .rst_pin_i(line), .addr_match_i(addr),
    .oscillator_stop_bit_i(stop), .conversion_rate_hi_i(rate_hi),
    .conversion_rate_lo_i(rate_lo), .aging_offset_i(aging), .temp_i(temp),
    .temp_vld_i(temp_vld), .rst_pin_o(drv), .rst_pin_oe_n_o(oe_n), .on_battery_o(on_bat),
    .osc_run_o(osc_run), .conv_req_o(conv_req), .cap_o(cap), .cap_upd_o(cap_upd));

  sprs_button_model partner (.press_i(press), .drv_i(drv), .oe_n_i(oe_n), .line_o(line),
                             .host_rst_n_o(host_rst_n));

  // --------------------------------------------------------------------
  // Shared helpers
  // --------------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic in_range(input int got, input int lo, input int hi);
    check((got >= lo && got <= hi) ? 32'(lo) : 32'(got), 32'(lo));
  endtask : in_range

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask : cyc

  // Count cycles until the line enable reaches a level
  task automatic wait_oe(input logic v, input int lim, output int n);
    n = 0;
    while (oe_n !== v && n < lim) begin
      cyc(1);
      n++;
    end
  endtask : wait_oe

  // Count cycles up to the next conversion request
  task automatic wait_conv(input int lim, output int n);
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (conv_req !== 1'b1 && n < lim);
  endtask : wait_conv

  function automatic logic [7:0] expc(input logic [9:0] t, input logic [7:0] a);
    return 8'(8'hC0 - 8'({t[9:4], 1'b0}) + a);
  endfunction : expc

  task automatic send_temp(input logic [9:0] t, input logic [7:0] a, input logic upd,
                           input logic [7:0] c);
    logic seen;
    seen  = 1'b0;
    aging = a;
    cyc(2);
    temp     = t;
    temp_vld = 1'b1;
    cyc(1);
    temp_vld = 1'b0;
    repeat (6) begin
      cyc(1);
      seen = seen | cap_upd;
    end
    check(seen, upd);
    check(cap, c);
  endtask : send_temp

  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  // Fresh battery: nothing runs until a bus address arms the oscillator
  task automatic t_arm();
    logic seen;
    seen = 1'b0;
    repeat (60) begin
      cyc(1);
      seen = seen | conv_req | osc_run;
    end
    check(seen, 1'b0);
    check(on_bat, 1'b1);
    addr = 1'b1;
    cyc(1);
    addr = 1'b0;
    cyc(8);
    check(osc_run, 1'b1);
    $display("test arm done");
  endtask : t_arm

  // Supply returns with the oscillator running: full recovery hold
  task automatic t_power();
    int n;
    pf  = 1'b1;
    bat = 1'b1;
    wait_oe(1'b1, 80, n);
    in_range(n, REC * TDIV, REC * TDIV + TDIV + 8);
    $display("test power up done");
  endtask : t_power

  // Capacitance follows table plus aging, only on a new temperature
  task automatic t_comp();
    send_temp(10'h155, 8'h05, 1'b1, expc(10'h155, 8'h05));
    send_temp(10'h155, 8'h05, 1'b0, expc(10'h155, 8'h05));
    send_temp(10'h155, 8'hF0, 1'b0, expc(10'h155, 8'h05));
    send_temp(10'h3F0, 8'hF0, 1'b1, expc(10'h3F0, 8'hF0));
    send_temp(10'h3F1, 8'h7F, 1'b1, expc(10'h3F1, 8'h7F));
    $display("test compensation done");
  endtask : t_comp

  // Supply selection table and power-fail reset
  task automatic t_supply();
    int n;
    int k;
    pf = 1'b0;
    wait_oe(1'b0, 20, n);
    in_range(n, 1, 8);
    for (k = 0; k < 4; k++) begin
      pf  = k[1];
      bat = k[0];
      cyc(10);
      check(on_bat, !k[1] && !k[0]);
      check(osc_run, 1'b1);
    end
    wait_oe(1'b1, 80, n);
    check(oe_n, 1'b1);
    $display("test supply done");
  endtask : t_supply

  // Stop bit on battery halts the oscillator, recovery then skips the hold
  task automatic t_stop();
    int n;
    pf   = 1'b0;
    bat  = 1'b0;
    stop = 1'b1;
    cyc(10);
    check(osc_run, 1'b0);
    check(oe_n, 1'b0);
    check(drv, 1'b0);
    check(host_rst_n, 1'b0);
    pf  = 1'b1;
    bat = 1'b1;
    wait_oe(1'b1, 40, n);
    in_range(n, 1, REC * TDIV - 1);
    stop = 1'b0;
    cyc(4);
    check(osc_run, 1'b1);
    $display("test stop done");
  endtask : t_stop

  // A tap and a long press each end in a reset pulse once released
  task automatic t_button();
    int n;
    press = 1'b1;
    wait_oe(1'b0, 12, n);
    in_range(n, 1, 10);
    cyc(2);
    press = 1'b0;
    wait_oe(1'b1, DB * TDIV + 12, n);
    in_range(n, DB * TDIV - 8, DB * TDIV + 6);
    wait_oe(1'b0, 12, n);
    check(oe_n, 1'b0);
    wait_oe(1'b1, RSTT * TDIV + 16, n);
    check(oe_n, 1'b1);
    cyc(8);
    check(oe_n, 1'b1);
    press = 1'b1;
    wait_oe(1'b0, 12, n);
    cyc(DB * TDIV + 20);
    check(line, 1'b0);
    check(oe_n, 1'b1);
    press = 1'b0;
    wait_oe(1'b0, 12, n);
    check(oe_n, 1'b0);
    wait_oe(1'b1, RSTT * TDIV + 16, n);
    in_range(n, RSTT * TDIV - 4, RSTT * TDIV + 8);
    check(osc_run, 1'b1);
    $display("test pushbutton done");
  endtask : t_button

  // Clock enable low freezes the sequencer, power fail acts once it returns
  task automatic t_freeze();
    int n;
    ce = 1'b0;
    pf = 1'b0;
    cyc(20);
    check(oe_n, 1'b1);
    ce = 1'b1;
    wait_oe(1'b0, 20, n);
    in_range(n, 1, 8);
    pf = 1'b1;
    wait_oe(1'b1, 80, n);
    check(oe_n, 1'b1);
    $display("test clock enable done");
  endtask : t_freeze

  // Conversion period for each rate code
  task automatic t_rate();
    int n;
    int k;
    for (k = 0; k < 4; k++) begin
      {rate_hi, rate_lo} = k[1:0];
      wait_conv(20000, n);
      wait_conv(20000, n);
      check(n, (64 * TPS * TDIV) << k);
    end
    $display("test conversion rate done");
  endtask : t_rate

  // --------------------------------------------------------------------
  // Main sequence and watchdog
  // --------------------------------------------------------------------
  initial begin
    {rst, tick, pf, bat, addr, stop, rate_hi, rate_lo, temp_vld, press} = 10'h200;
    aging     = 8'h00;
    temp      = 10'h000;
    tick_cnt  = 0;
    error_cnt = 0;
    comparisons = 0;
    ce          = 1'b1;
    cyc(3);
    check({oe_n, cap, on_bat, osc_run}, {1'b0, 8'h80, 2'b00});
    rst = 1'b0;
    t_arm();
    t_power();
    t_comp();
    t_supply();
    t_stop();
    t_button();
    t_freeze();
    t_rate();
    summarize();
  end

  initial begin
    #(25 * 120000);
    error_cnt++;
    summarize();
  end
endmodule : tb_sprs_top
